// ### pin_function_and_pull_control.sv
// APB-programmed pin function routing and internal pull resistor control

// What this block does
// [R01] Option clear: keyboard-mouse or DMA on G
// [R02] Option set: DMA, SD2 or memory-card on G
// [R03] Select register bit zero is the option
// [R04] Software-controlled internal pulls on I/O pins
// [R05] Bit one disables pull, reset disables all
// [R06] Bus data lines pulled down, one-to-one
// [R07] Display lines 17..0 pulled up, rest reserved
// [R08] Port C bits 15..0 pull up
// [R09] Port D bits 9..0 pull up
// [R10] Port E: down 6..0, up 13..8, 7 none
// [R11] Port F mixed directions, pin 0 none
// [R12] Port G mixed directions, 10 and 8 none
// [R13] Port H bits 7..0 pull up
// [R14] Port I bits 27..16 pull drive lines up
// [R15] Port I pins 10,5 down, others up
// [R16] Port C select: GPIO, NAND, keypad, display
// [R17] Port F select: GPIO or reduced Ethernet
module pin_function_and_pull_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pull enables, high means resistor connected
  output logic      [31:0] bus_data_pull_down,
  output logic      [17:0] display_data_pull_up,
  output logic      [15:0] port_c_pull_up,
  output logic      [9:0]  port_d_pull_up,
  output logic      [13:0] port_e_pull_up,
  output logic      [13:0] port_e_pull_down,
  output logic      [9:0]  port_f_pull_up,
  output logic      [9:0]  port_f_pull_down,
  output logic      [16:0] port_g_pull_up,
  output logic      [16:0] port_g_pull_down,
  output logic      [7:0]  port_h_pull_up,
  output logic      [15:0] port_i_pull_up,
  output logic      [15:0] port_i_pull_down,
  output logic      [11:0] drive_data_lines_pull_up,
  // Function routing
  output logic      [3:0]  port_c_route,
  output logic             port_f_rmii,
  output logic [3:0][2:0]  port_g_pin_func,
  output logic      [3:0]  port_d_func_sel,
  output logic      [5:0]  port_e_func_sel
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [3:0] reg_index(input logic [31:0] addr);
    logic [3:0] idx;
    idx = pin_mux_pkg::NO_IDX;
    for (int i = 0; i < pin_mux_pkg::NUM_REGS; i++) begin
      if (addr == pin_mux_pkg::REG_ADDR[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : reg_index

  // Port C select code to one-hot route
  function automatic logic [3:0] c_route(input logic [1:0] code);
    logic [3:0] r;
    unique case (code)
      2'b00:   r = pin_mux_pkg::C_GPIO;
      2'b01:   r = pin_mux_pkg::C_NAND;
      2'b10:   r = pin_mux_pkg::C_KEYPAD;
      2'b11:   r = pin_mux_pkg::C_DISPLAY;
    endcase
    return r;
  endfunction : c_route

  // Port G pin pair (0: pins 5:4 .. 3: pins 11:10) under the option bit
  function automatic logic [2:0] g_pair(input logic opt, input logic [3:0] sel,
                                        input int pair);
    logic [2:0] f;
    f = pin_mux_pkg::GF_GPIO;
    if (!opt) begin
      if (sel[pair]) begin
        f = (pair >= 2) ? pin_mux_pkg::GF_KBD_MOUSE : pin_mux_pkg::GF_EXT_DMA;
      end
    end else if (pair >= 1) begin
      // Pins 11:6 move as one group between the two card interfaces
      f = sel[2] ? pin_mux_pkg::GF_MEM_CARD2 : pin_mux_pkg::GF_SD_CARD2;
    end else begin
      unique case (sel[1:0])
        2'b00:   f = pin_mux_pkg::GF_GPIO;
        2'b01:   f = pin_mux_pkg::GF_EXT_DMA;
        2'b10:   f = pin_mux_pkg::GF_SD_CARD2;
        2'b11:   f = pin_mux_pkg::GF_MEM_CARD2;
      endcase
    end
    return f;
  endfunction : g_pair

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic [3:0]  acc_idx;
  logic        acc_hit;
  logic        wr_en;
  logic [31:0] strobe_mask;
  logic [31:0] regs_q [pin_mux_pkg::NUM_REGS];
  logic [31:0] prdata_q;

  assign acc_idx     = reg_index(paddr);
  assign acc_hit     = (acc_idx != pin_mux_pkg::NO_IDX);
  assign wr_en       = psel && penable && pwrite && acc_hit;
  assign strobe_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  // Zero wait states; unmapped addresses answer with an error
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !acc_hit;
  assign prdata      = prdata_q;

  // Reserved bits never store, so they read as zero
  for (genvar i = 0; i < pin_mux_pkg::NUM_REGS; i++) begin : g_reg
    logic [31:0] wmask;
    assign wmask = strobe_mask & pin_mux_pkg::REG_MASK[i];
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        regs_q[i] <= pin_mux_pkg::REG_RESET[i]; // R05
      end else if (wr_en && acc_idx == 4'(i)) begin
        regs_q[i] <= (regs_q[i] & ~wmask) | (pwdata & wmask);
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= acc_hit ? regs_q[acc_idx] : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pull resistor outputs
  // ----------------------------------------------------------------
  // A cleared bit connects the resistor; direction is fixed per pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_data_pull_down       <= '0;
      display_data_pull_up     <= '0;
      port_c_pull_up           <= '0;
      port_d_pull_up           <= '0;
      port_e_pull_up           <= '0;
      port_e_pull_down         <= '0;
      port_f_pull_up           <= '0;
      port_f_pull_down         <= '0;
      port_g_pull_up           <= '0;
      port_g_pull_down         <= '0;
      port_h_pull_up           <= '0;
      port_i_pull_up           <= '0;
      port_i_pull_down         <= '0;
      drive_data_lines_pull_up <= '0;
    end else begin
      bus_data_pull_down       <= ~regs_q[0];                              // R04 R06
      display_data_pull_up     <= ~regs_q[1][17:0];                        // R07
      port_c_pull_up           <= ~regs_q[2][15:0];                        // R08
      port_d_pull_up           <= ~regs_q[3][9:0];                         // R09
      port_e_pull_up           <= ~regs_q[4][13:0] & pin_mux_pkg::E_UP_PINS;   // R10
      port_e_pull_down         <= ~regs_q[4][13:0] & pin_mux_pkg::E_DOWN_PINS; // R10
      port_f_pull_up           <= ~regs_q[5][9:0] & pin_mux_pkg::F_UP_PINS;    // R11
      port_f_pull_down         <= ~regs_q[5][9:0] & pin_mux_pkg::F_DOWN_PINS;  // R11
      port_g_pull_up           <= ~regs_q[6][16:0] & pin_mux_pkg::G_UP_PINS;   // R12
      port_g_pull_down         <= ~regs_q[6][16:0] & pin_mux_pkg::G_DOWN_PINS; // R12
      port_h_pull_up           <= ~regs_q[7][7:0];                         // R13
      port_i_pull_up           <= ~regs_q[8][15:0] & pin_mux_pkg::I_UP_PINS;   // R15
      port_i_pull_down         <= ~regs_q[8][15:0] & pin_mux_pkg::I_DOWN_PINS; // R15
      drive_data_lines_pull_up <= ~regs_q[8][27:16];                       // R14
    end
  end

  // ----------------------------------------------------------------
  // Function routing outputs
  // ----------------------------------------------------------------
  logic [31:0] sel_r;
  logic        g_opt;
  assign sel_r = regs_q[pin_mux_pkg::SEL_IDX];
  assign g_opt = sel_r[pin_mux_pkg::G_OPTION_BIT]; // R03

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_c_route    <= pin_mux_pkg::C_GPIO;
      port_f_rmii     <= 1'b0;
      port_d_func_sel <= '0;
      port_e_func_sel <= '0;
    end else begin
      port_c_route    <= c_route(sel_r[pin_mux_pkg::C_SEL_LSB +: 2]); // R16
      port_f_rmii     <= sel_r[pin_mux_pkg::F_SEL_BIT];              // R17
      port_d_func_sel <= sel_r[pin_mux_pkg::D_SEL_LSB +: 4];
      port_e_func_sel <= sel_r[pin_mux_pkg::E_SEL_LSB +: 6];
    end
  end

  for (genvar p = 0; p < 4; p++) begin : g_pair_out
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        port_g_pin_func[p] <= pin_mux_pkg::GF_GPIO;
      end else begin
        port_g_pin_func[p] <= g_pair(g_opt, sel_r[pin_mux_pkg::G_SEL_LSB +: 4], p); // R01 R02
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic full_wr;
  assign full_wr = wr_en && (pstrb == 4'hF);

  property p_reset_pulls_off;
    $fell(sys_rst) |-> (bus_data_pull_down == '0) && (port_i_pull_up == '0)
      && (port_g_pull_down == '0) && (drive_data_lines_pull_up == '0);
  endproperty
  a_reset_pulls_off: assert property (p_reset_pulls_off) // R05
    else $error("pull active right after reset");

  property p_bus_down;
    full_wr && acc_idx == 4'h0 |-> ##2 bus_data_pull_down == ~$past(pwdata, 2);
  endproperty
  a_bus_down: assert property (p_bus_down) // R06
    else $error("bus data pull-down does not follow write");

  property p_display_up;
    full_wr && acc_idx == 4'h1 |-> ##2 display_data_pull_up == ~$past(pwdata[17:0], 2);
  endproperty
  a_display_up: assert property (p_display_up) // R07
    else $error("display pull-up does not follow write");

  property p_port_d_reserved;
    psel && !penable && !pwrite && acc_idx == 4'h3 |=> prdata[31:11] == '0;
  endproperty
  a_port_d_reserved: assert property (p_port_d_reserved) // R09
    else $error("port D reserved bits read non-zero");

  property p_port_e_dirs;
    !port_e_pull_up[7] && !port_e_pull_down[7] && !(|(port_e_pull_up & port_e_pull_down));
  endproperty
  a_port_e_dirs: assert property (p_port_e_dirs) // R10
    else $error("port E pull direction wrong");

  property p_port_f_write;
    full_wr && acc_idx == 4'h5 && pwdata[1:0] == 2'b00
      |-> ##2 port_f_pull_down[1] && !port_f_pull_up[1] && !port_f_pull_down[0];
  endproperty
  a_port_f_write: assert property (p_port_f_write) // R11
    else $error("port F pin pull wrong");

  property p_port_g_none;
    !port_g_pull_up[10] && !port_g_pull_down[10] && !port_g_pull_up[8]
      && !port_g_pull_down[8] && port_g_pull_up[11:0] == '0;
  endproperty
  a_port_g_none: assert property (p_port_g_none) // R12
    else $error("port G pull direction wrong");

  property p_drive_up;
    full_wr && acc_idx == 4'h8 |-> ##2
      drive_data_lines_pull_up == ~$past(pwdata[27:16], 2)
      && port_i_pull_down == (~$past(pwdata[15:0], 2) & 16'h0420);
  endproperty
  a_drive_up: assert property (p_drive_up) // R14
    else $error("port I pulls do not follow write");

  property p_g_opt0;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX && !pwdata[0] && pwdata[21]
      |-> ##2 port_g_pin_func[3] == pin_mux_pkg::GF_KBD_MOUSE;
  endproperty
  a_g_opt0: assert property (p_g_opt0) // R01
    else $error("port G option clear routing wrong");

  property p_g_opt1;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX && pwdata[0] && pwdata[19:18] == 2'b10
      |-> ##2 port_g_pin_func[0] == pin_mux_pkg::GF_SD_CARD2;
  endproperty
  a_g_opt1: assert property (p_g_opt1) // R02
    else $error("port G option set routing wrong");

  property p_c_route;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX && pwdata[3:2] == 2'b10
      |-> ##2 port_c_route == pin_mux_pkg::C_KEYPAD;
  endproperty
  a_c_route: assert property (p_c_route) // R16
    else $error("port C route wrong");

  property p_f_route;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX |-> ##2 port_f_rmii == $past(pwdata[1], 2);
  endproperty
  a_f_route: assert property (p_f_route) // R17
    else $error("port F route wrong");

  property p_port_c_up;
    full_wr && acc_idx == 4'h2
      |-> ##2 port_c_pull_up == ~$past(pwdata[15:0], 2);
  endproperty
  a_port_c_up: assert property (p_port_c_up) // R08
    else $error("port C pull-up does not follow write");

  property p_port_d_up;
    full_wr && acc_idx == 4'h3
      |-> ##2 port_d_pull_up == ~$past(pwdata[9:0], 2);
  endproperty
  a_port_d_up: assert property (p_port_d_up) // R09
    else $error("port D pull-up does not follow write");

  property p_port_h_up;
    full_wr && acc_idx == 4'h7
      |-> ##2 port_h_pull_up == ~$past(pwdata[7:0], 2);
  endproperty
  a_port_h_up: assert property (p_port_h_up) // R13
    else $error("port H pull-up does not follow write");

  property p_port_e_write;
    full_wr && acc_idx == 4'h4 |-> ##2
      port_e_pull_down == (~$past(pwdata[13:0], 2) & 14'h007F)
      && port_e_pull_up == (~$past(pwdata[13:0], 2) & 14'h3F00);
  endproperty
  a_port_e_write: assert property (p_port_e_write) // R10
    else $error("port E pulls do not follow write");

  property p_port_g_write;
    full_wr && acc_idx == 4'h6 |-> ##2
      port_g_pull_down == (~$past(pwdata[16:0], 2) & 17'h0_0AFF)
      && port_g_pull_up == (~$past(pwdata[16:0], 2) & 17'h1_F000);
  endproperty
  a_port_g_write: assert property (p_port_g_write) // R12
    else $error("port G pulls do not follow write");

  property p_port_i_up;
    full_wr && acc_idx == 4'h8 |-> ##2
      port_i_pull_up == (~$past(pwdata[15:0], 2) & 16'hFBDF);
  endproperty
  a_port_i_up: assert property (p_port_i_up) // R15
    else $error("port I pull-up does not follow write");

  property p_g_opt_group;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX && pwdata[0] |-> ##2
      port_g_pin_func[2] == ($past(pwdata[20], 2) ? pin_mux_pkg::GF_MEM_CARD2
                                                  : pin_mux_pkg::GF_SD_CARD2);
  endproperty
  a_g_opt_group: assert property (p_g_opt_group) // R03
    else $error("port G option does not switch the card group");

  property p_display_reserved;
    psel && !penable && !pwrite && acc_idx == 4'h1 |=> prdata[31:18] == '0;
  endproperty
  a_display_reserved: assert property (p_display_reserved) // R07
    else $error("display reserved bits read non-zero");

  property p_c_route_all;
    full_wr && acc_idx == pin_mux_pkg::SEL_IDX
      |-> ##2 port_c_route == 4'(4'h1 << $past(pwdata[3:2], 2));
  endproperty
  a_c_route_all: assert property (p_c_route_all) // R16
    else $error("port C route does not follow select code");

  c_unmapped: cover property (psel && penable && pslverr);
  c_opt_mem:  cover property (port_g_pin_func[3] == pin_mux_pkg::GF_MEM_CARD2);
  c_read_sel: cover property (psel && penable && !pwrite && acc_idx == pin_mux_pkg::SEL_IDX);
  c_opt_sd:   cover property (port_g_pin_func[0] == pin_mux_pkg::GF_SD_CARD2);
  c_rmii:     cover property (port_f_rmii);

endmodule : pin_function_and_pull_control

// ### pin_mux_pkg.sv
// Register map, field layout and pin direction constants for the pin mux block
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NUM_REGS     = 10;
  localparam logic [3:0]  SEL_IDX      = 4'h9;
  localparam logic [3:0]  NO_IDX       = 4'hA;

  // Index order: bus, display, C, D, E, F, G, H, I, function select
  localparam logic [31:0] REG_ADDR [NUM_REGS] = '{
    32'hB000_0010, 32'hB000_0014, 32'hB000_0018, 32'hB000_001C, 32'hB000_0020,
    32'hB000_0024, 32'hB000_0028, 32'hB000_002C, 32'hB000_0030, 32'hB000_000C
  };

  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'hFFFF_FFFF, 32'h0003_FFFF, 32'h0000_FFFF, 32'h0000_07FF, 32'h0000_3FFF,
    32'h0000_03FF, 32'h0001_FFFF, 32'h0000_00FF, 32'h0FFF_FFFF, 32'h0000_0000
  };

  // Writable bits; everything else reads as zero
  localparam logic [31:0] REG_MASK [NUM_REGS] = '{
    32'hFFFF_FFFF, 32'h0003_FFFF, 32'h0000_FFFF, 32'h0000_07FF, 32'h0000_3FFF,
    32'h0000_03FF, 32'h0001_FFFF, 32'h0000_00FF, 32'h0FFF_FFFF, 32'h003C_3FFF
  };

  // ----------------------------------------------------------------
  // Function select fields
  // ----------------------------------------------------------------
  localparam int G_OPTION_BIT  = 0;
  localparam int F_SEL_BIT     = 1;
  localparam int C_SEL_LSB     = 2;
  localparam int D_SEL_LSB     = 4;
  localparam int E_SEL_LSB     = 8;
  localparam int G_SEL_LSB     = 18;

  // Port G pin-pair function codes
  localparam logic [2:0] GF_GPIO      = 3'h0;
  localparam logic [2:0] GF_KBD_MOUSE = 3'h1;
  localparam logic [2:0] GF_EXT_DMA   = 3'h2;
  localparam logic [2:0] GF_SD_CARD2  = 3'h3;
  localparam logic [2:0] GF_MEM_CARD2 = 3'h4;

  // Port C one-hot routes
  localparam logic [3:0] C_GPIO    = 4'h1;
  localparam logic [3:0] C_NAND    = 4'h2;
  localparam logic [3:0] C_KEYPAD  = 4'h4;
  localparam logic [3:0] C_DISPLAY = 4'h8;

  // ----------------------------------------------------------------
  // Pull direction per pin
  // ----------------------------------------------------------------
  localparam logic [13:0] E_DOWN_PINS = 14'h007F;
  localparam logic [13:0] E_UP_PINS   = 14'h3F00;
  localparam logic [9:0]  F_DOWN_PINS = 10'h332;
  localparam logic [9:0]  F_UP_PINS   = 10'h0CC;
  localparam logic [16:0] G_DOWN_PINS = 17'h0_0AFF;
  localparam logic [16:0] G_UP_PINS   = 17'h1_F000;
  localparam logic [15:0] I_DOWN_PINS = 16'h0420;
  localparam logic [15:0] I_UP_PINS   = 16'hFBDF;

endpackage : pin_mux_pkg

// ### pad_model.sv
// Pad model: resolves port E pin levels from the internal pull enables
module pad_model (
  // Clock
  input  wire logic        clk,
  // Pull enables from the block
  input  wire logic [13:0] pull_up,
  input  wire logic [13:0] pull_down,
  // Resolved pin levels
  output logic      [13:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] float_q = 14'h0000;
  // A floating pin wanders, so nothing may rely on its level
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      pad[i] = pull_up[i] ? 1'b1 : (pull_down[i] ? 1'b0 : float_q[i]);
    end
  end
endmodule : pad_model

// ### tb_pin_function_and_pull_control.sv
// Self-checking bench for the pin function and pull control block
module tb_pin_function_and_pull_control;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
  logic        clk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, pready, pslverr, port_f_rmii;
  logic [31:0] paddr, pwdata, prdata, bus_data_pull_down, r;
  logic [3:0]  pstrb, port_c_route, port_d_func_sel;
  logic [17:0] display_data_pull_up;
  logic [15:0] port_c_pull_up, port_i_pull_up, port_i_pull_down;
  logic [9:0]  port_d_pull_up, port_f_pull_up, port_f_pull_down;
  logic [13:0] port_e_pull_up, port_e_pull_down, pad_e;
  logic [16:0] port_g_pull_up, port_g_pull_down;
  logic [7:0]  port_h_pull_up;
  logic [11:0] drive_data_lines_pull_up;
  logic [3:0][2:0] port_g_pin_func;
  logic [5:0]  port_e_func_sel;
  logic        e;
  int          checked = 0;
  int          miscompares = 0;
  int          cycles = 0;
  logic [31:0] rst_val [10] = '{32'hFFFF_FFFF, 32'h0003_FFFF, 32'h0000_FFFF, 32'h0000_07FF,
    32'h0000_3FFF, 32'h0000_03FF, 32'h0001_FFFF, 32'h0000_00FF, 32'h0FFF_FFFF, 32'h0000_0000};
  logic [31:0] sel_val [4] = '{32'h003C_0A5A, 32'h0000_0000, 32'h0018_3FA5, 32'h0004_00FF};
  // Expected {port C route, port F select, port D field, port E field}
  logic [14:0] rfn [4] = '{{4'h4, 1'b1, 4'h5, 6'h0A}, {4'h1, 1'b0, 4'h0, 6'h00},
    {4'h2, 1'b0, 4'hA, 6'h3F}, {4'h8, 1'b1, 4'hF, 6'h00}};
  logic [11:0] gfn [4] = '{12'h252, 12'h000, 12'h923, 12'h6DA};

  pin_function_and_pull_control i_pin_function_and_pull_control (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_data_pull_down(bus_data_pull_down),
    .display_data_pull_up(display_data_pull_up), .port_c_pull_up(port_c_pull_up),
    .port_d_pull_up(port_d_pull_up), .port_e_pull_up(port_e_pull_up),
    .port_e_pull_down(port_e_pull_down), .port_f_pull_up(port_f_pull_up),
    .port_f_pull_down(port_f_pull_down), .port_g_pull_up(port_g_pull_up),
    .port_g_pull_down(port_g_pull_down), .port_h_pull_up(port_h_pull_up),
    .port_i_pull_up(port_i_pull_up), .port_i_pull_down(port_i_pull_down),
    .drive_data_lines_pull_up(drive_data_lines_pull_up), .port_c_route(port_c_route),
    .port_f_rmii(port_f_rmii), .port_g_pin_func(port_g_pin_func),
    .port_d_func_sel(port_d_func_sel), .port_e_func_sel(port_e_func_sel));

  pad_model i_pad_model (.clk(clk), .pull_up(port_e_pull_up),
    .pull_down(port_e_pull_down), .pad(pad_e));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // The whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Outputs follow a write one edge after the access edge
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset pulls", 1'b0, |{bus_data_pull_down, port_e_pull_down, port_i_pull_up})
    `CHK("reset route", 4'h1, port_c_route)
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, pin_mux_pkg::REG_ADDR[i], '0, 4'h0);
      `CHK("reset value", rst_val[i], r)
      `CHK("mapped error", 1'b0, e)
    end
    apb(1'b0, 32'hB000_0040, '0, 4'h0);
    `CHK("unmapped data", 32'h0000_0000, r)
    `CHK("unmapped error", 1'b1, e)
    // Only the low byte lane clears, so only pins 7..0 get pulls
    apb(1'b1, pin_mux_pkg::REG_ADDR[2], '0, 4'h1);
    settle();
    `CHK("port c strobe", 16'h00FF, port_c_pull_up)
    for (int i = 0; i < 9; i++) apb(1'b1, pin_mux_pkg::REG_ADDR[i], '0, 4'hF);
    settle();
    `CHK("bus down", 32'hFFFF_FFFF, bus_data_pull_down)
    `CHK("display up", 18'h3_FFFF, display_data_pull_up)
    `CHK("port c up", 16'hFFFF, port_c_pull_up)
    `CHK("port d up", 10'h3FF, port_d_pull_up)
    `CHK("port e", {14'h3F00, 14'h007F}, {port_e_pull_up, port_e_pull_down})
    `CHK("port f", {10'h0CC, 10'h332}, {port_f_pull_up, port_f_pull_down})
    `CHK("port g", {17'h1_F000, 17'h0_0AFF}, {port_g_pull_up, port_g_pull_down})
    `CHK("port h up", 8'hFF, port_h_pull_up)
    `CHK("drive up", 12'hFFF, drive_data_lines_pull_up)
    `CHK("port i", {16'hFBDF, 16'h0420}, {port_i_pull_up, port_i_pull_down})
    `CHK("pads e", 13'h1F80, {pad_e[13:8], pad_e[6:0]})
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, pin_mux_pkg::REG_ADDR[i], 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, pin_mux_pkg::REG_ADDR[i], '0, 4'h0);
      `CHK("reserved bits", pin_mux_pkg::REG_MASK[i], r)
    end
    settle();
    `CHK("pulls off", 1'b0, |{bus_data_pull_down, port_g_pull_up, port_i_pull_down})
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pin_mux_pkg::REG_ADDR[pin_mux_pkg::SEL_IDX], sel_val[i], 4'hF);
      apb(1'b0, pin_mux_pkg::REG_ADDR[pin_mux_pkg::SEL_IDX], '0, 4'h0);
      `CHK("select readback", sel_val[i], r)
      settle();
      `CHK("port g func", gfn[i], port_g_pin_func)
      `CHK("port c route", rfn[i][14:11], port_c_route)
      `CHK("f d e sel", rfn[i][10:0], {port_f_rmii, port_d_func_sel, port_e_func_sel})
    end
    summarize();
  end
endmodule : tb_pin_function_and_pull_control
